// file: rtl/tx_request_pkg.sv
// Shared constants, types and the command decode helper function for the transmit request block
package tx_request_pkg;

    // Register port byte offsets
    localparam logic [11:0] OFF_TX_EVENT = 12'h108;
    localparam logic [11:0] OFF_TX_CFG = 12'h10e;
    localparam logic [11:0] OFF_TX_CMD = 12'h144;
    localparam logic [11:0] OFF_TX_LEN = 12'h146;
    localparam logic [11:0] OFF_BUF_CFG = 12'h116;
    localparam logic [11:0] OFF_BUF_EVENT = 12'h12c;
    localparam logic [11:0] OFF_LINE_CTL = 12'h112;
    localparam logic [11:0] OFF_BUS_STATUS = 12'h138;
    localparam logic [11:0] OFF_TEST_CTL = 12'h118;
    localparam logic [11:0] OFF_TX_DATA = 12'ha00;

    // Command word fields
    localparam int CMD_START_LSB = 6;
    localparam int CMD_ABORT = 8;
    localparam int CMD_SINGLE = 9;
    localparam int CMD_CRC_OFF = 12;
    localparam int CMD_PAD_OFF = 13;

    // Line control and test control fields
    localparam int LC_SER_TX_EN = 7;
    localparam int LC_FORCE_AUI = 8;
    localparam int LC_AUTO_SEL = 9;
    localparam int LC_MOD_BACKOFF = 11;
    localparam int LC_DEFER_OFF = 13;
    localparam int TC_LINK_TEST_OFF = 7;

    // Event and status bit positions (event bits shared with the enables)
    localparam int EV_SEND_OK = 8;
    localparam int EV_LATE_COL = 9;
    localparam int EV_ANY_COL = 11;
    localparam int EV_SIXTEEN = 15;
    localparam int BEV_SPACE = 8;
    localparam int BEV_UNDERRUN = 9;
    localparam int BS_BID_ERR = 7;
    localparam int BS_READY_NOW = 8;

    // Reset values
    localparam logic [15:0] RST_REG = 16'h0000;

    // Frame size figures in bytes, the preamble and SFD byte values and the retry limit
    localparam logic [10:0] THR_A = 11'd5;
    localparam logic [10:0] THR_B = 11'd381;
    localparam logic [10:0] THR_C = 11'd1021;
    localparam logic [10:0] LEN_MIN = 11'd3;
    localparam logic [10:0] PAD_TO = 11'd60;
    localparam logic [15:0] LEN_MAX_CRC = 16'd1514;
    localparam logic [15:0] LEN_MAX_NOCRC = 16'd1518;
    localparam logic [10:0] PRE_BYTES = 11'd8;
    localparam logic [10:0] CRC_BYTES = 11'd4;
    localparam logic [10:0] LATE_IDX = 11'd72;
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hd5;
    localparam logic [3:0] MAX_RETRY = 4'hf;

    // Timing: bit time and inter-frame gap, converted to clock cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_TIME_NS = 100;
    localparam int GAP_NS = 9600;
    localparam int BYTE_CLKS = (8 * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CLKS = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // CRC-32, reflected form
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;

    typedef struct packed {
        logic pad_disable;
        logic crc_suppress;
        logic single_attempt;
        logic abort;
        logic [1:0] start_sel;
    } tx_cmd_t;

    typedef struct packed {
        logic frame_active;
        logic strobe;
        logic [7:0] data;
    } tx_byte_t;

    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_READY, ST_LOAD, ST_SEND, ST_GAP} req_state_t;

    // Pick the command fields out of a written word
    function automatic tx_cmd_t decode_cmd(input logic [15:0] w);
        decode_cmd.pad_disable = w[CMD_PAD_OFF];
        decode_cmd.crc_suppress = w[CMD_CRC_OFF];
        decode_cmd.single_attempt = w[CMD_SINGLE];
        decode_cmd.abort = w[CMD_ABORT];
        decode_cmd.start_sel = w[CMD_START_LSB +: 2];
    endfunction

endpackage

// file: rtl/tx_crc32.sv
// Byte-wide CRC-32 accumulator for the outgoing frame
`timescale 1ns/1ps
module tx_crc32
    import tx_request_pkg::*;
(
    input wire logic mclk, // Device clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic init, // Restart the sum
    input wire logic en, // Fold in one byte
    input wire logic [7:0] data, // Byte to fold in
    output logic [31:0] crc_r // Running remainder
);

    // One byte folded per call, lsb first as the line sends it
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[0] ^ d[i])
                r = (r >> 1) ^ CRC_POLY;
            else
                r = r >> 1;
        end
        return r;
    endfunction

    // Init wins so a retry always starts clean
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            crc_r <= CRC_INIT;
        else if (init)
            crc_r <= CRC_INIT;
        else if (en)
            crc_r <= crc_step(crc_r, data);
    end

endmodule

// file: rtl/tx_request_ctrl.sv
// Transmit request control: register port, frame buffer, start threshold, pad and CRC
`timescale 1ns/1ps
module tx_request_ctrl
    import tx_request_pkg::*;
#(
    parameter int BUF_WORDS = 768 // Frame buffer depth in 16-bit words
)
(
    input wire logic mclk, // Device clock, 10 MHz
    input wire logic reset, // Chip-wide reset, active high
    input wire logic [11:0] addr, // Register byte address
    input wire logic wr_strobe, // One-cycle write request
    input wire logic rd_strobe, // One-cycle read request
    input wire logic [15:0] wdata, // Write data
    output logic [15:0] rdata_r, // Read data, valid the cycle after rd_strobe
    input wire logic link_ok, // Link pulses seen on twisted pair
    input wire logic collision, // Collision seen on the line
    output tx_byte_t tx_out_r, // Outgoing byte stream
    output logic use_aui_r, // Attachment unit selected
    output logic mod_backoff_r, // Modified backoff algorithm chosen
    output logic defer_off_r, // Two-part deferral disabled
    output logic irq_r // Enabled event pending
);

    req_state_t state_r;
    tx_cmd_t cmd_r;
    logic [15:0] cmd_word_r;
    logic [10:0] len_r;
    logic [10:0] flen_r;
    logic [10:0] loaded_r;
    logic [10:0] idx_r;
    logic [3:0] attempts_r;
    logic [7:0] div_r;
    logic [7:0] gap_r;
    logic [15:0] line_ctl_r;
    logic [15:0] test_ctl_r;
    logic [15:0] tx_cfg_r;
    logic [15:0] buf_cfg_r;
    logic [15:0] tx_event_r;
    logic [15:0] buf_event_r;
    logic bid_error_r;
    logic [15:0] mem [BUF_WORDS];
    logic [31:0] crc_r;

    logic cmd_wr, len_wr, data_wr, status_rd;
    logic tick, len_ok, tx_allowed, start_ok;
    logic [10:0] d, total, thr;
    logic in_pre, in_data, in_pad, in_crc, last, starved;
    logic col_hit, late, fail, ok_done, feed_crc;
    logic [7:0] byte_nxt;
    logic [15:0] cur_word;
    logic [1:0] crc_k;

    assign cmd_wr = wr_strobe && addr == OFF_TX_CMD;
    assign len_wr = wr_strobe && addr == OFF_TX_LEN;
    assign data_wr = wr_strobe && addr == OFF_TX_DATA;
    assign status_rd = rd_strobe && addr == OFF_BUS_STATUS;

    // Threshold in bytes; a frame shorter than the threshold starts once complete
    function automatic logic [10:0] start_thr(input logic [1:0] sel, input logic [10:0] len);
        logic [10:0] t;
        case (sel)
            2'b00: t = THR_A;
            2'b01: t = THR_B;
            2'b10: t = THR_C;
            default: t = len;
        endcase
        return (t < len) ? t : len;
    endfunction

    // Length acceptance: too short or too long for the CRC mode is refused
    function automatic logic length_good(input logic [15:0] len, input logic crc_off);
        if (len < 16'(LEN_MIN))
            return 1'b0;
        else if (crc_off)
            return len <= LEN_MAX_NOCRC;
        else
            return len <= LEN_MAX_CRC;
    endfunction

    assign len_ok = length_good(wdata, cmd_r.crc_suppress);
    assign thr = start_thr(cmd_r.start_sel, len_r);

    // Gate on enable and link; auto or forced unit needs no link pulses
    assign tx_allowed = line_ctl_r[LC_SER_TX_EN]
        && (use_aui_r || link_ok || test_ctl_r[TC_LINK_TEST_OFF]);
    assign start_ok = state_r == ST_LOAD && loaded_r >= thr && tx_allowed;

    // Where in the frame the next byte falls
    always_comb
    begin
        d = idx_r - PRE_BYTES;
        total = PRE_BYTES + flen_r + (cmd_r.crc_suppress ? 11'd0 : CRC_BYTES);
        in_pre = idx_r < PRE_BYTES;
        in_data = !in_pre && d < len_r;
        in_pad = !in_pre && !in_data && d < flen_r;
        in_crc = !in_pre && d >= flen_r;
        last = idx_r == total - 11'd1;
        starved = in_data && d >= loaded_r;
        cur_word = mem[d[10:1]];
        crc_k = 2'(d - flen_r);
        if (in_pre)
            byte_nxt = (idx_r == PRE_BYTES - 11'd1) ? SFD_BYTE : PRE_BYTE;
        else if (in_data)
            byte_nxt = d[0] ? cur_word[15:8] : cur_word[7:0];
        else if (in_pad)
            byte_nxt = 8'h00;
        else
            byte_nxt = ~crc_r[8 * crc_k +: 8];
    end

    // Line events in the current cycle
    assign col_hit = state_r == ST_SEND && collision;
    assign late = idx_r >= LATE_IDX;
    assign fail = col_hit && (cmd_r.single_attempt || late || attempts_r == MAX_RETRY);
    assign ok_done = state_r == ST_SEND && tick && !collision && !starved && last;
    assign feed_crc = state_r == ST_SEND && tick && !collision && (in_data || in_pad)
        && !starved;

    tx_crc32 u_crc (
        .mclk(mclk),
        .reset(reset),
        .init(start_ok || state_r == ST_GAP),
        .en(feed_crc),
        .data(byte_nxt),
        .crc_r(crc_r)
    );

    // Byte-rate enable: one byte time on a 10 Mb/s line
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            div_r <= 8'h00;
        else if (state_r != ST_SEND || div_r == 8'(BYTE_CLKS - 1))
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end
    assign tick = state_r == ST_SEND && div_r == 8'(BYTE_CLKS - 1);

    // Request sequence and frame life cycle; abort wins over everything
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            state_r <= ST_IDLE;
        else if (cmd_wr && wdata[CMD_ABORT])
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (cmd_wr)
                        state_r <= ST_CMD;
                ST_CMD:
                    if (len_wr)
                        state_r <= len_ok ? ST_READY : ST_IDLE;
                ST_READY:
                    if (cmd_wr)
                        state_r <= ST_CMD;
                    else if (status_rd)
                        state_r <= ST_LOAD;
                ST_LOAD:
                    if (start_ok)
                        state_r <= ST_SEND;
                ST_SEND:
                    if (fail)
                        state_r <= ST_IDLE;
                    else if (col_hit)
                        state_r <= ST_GAP;
                    else if (tick && (starved || last))
                        state_r <= ST_IDLE;
                ST_GAP:
                    if (gap_r == 8'(GAP_CLKS - 1) && tx_allowed)
                        state_r <= ST_SEND;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Command word: readback copy always, active copy only in the idle, command and ready states
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cmd_word_r <= RST_REG;
            cmd_r <= '0;
        end
        else if (cmd_wr)
        begin
            cmd_word_r <= wdata;
            if (state_r == ST_IDLE || state_r == ST_CMD || state_r == ST_READY)
                cmd_r <= decode_cmd(wdata);
        end
    end

    // Length and padded length; runts keep their own length when padding is off
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            len_r <= 11'd0;
            flen_r <= 11'd0;
        end
        else if (len_wr && state_r == ST_CMD && len_ok)
        begin
            len_r <= wdata[10:0];
            if (!cmd_r.pad_disable && wdata[10:0] < PAD_TO)
                flen_r <= PAD_TO;
            else
                flen_r <= wdata[10:0];
        end
    end

    // Loaded-byte count for the frame buffer; cleared on commit, on abort and while idle
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            loaded_r <= 11'd0;
        else if ((cmd_wr && wdata[CMD_ABORT]) || state_r == ST_IDLE
            || (status_rd && state_r == ST_READY))
            loaded_r <= 11'd0;
        else if (data_wr && (state_r == ST_LOAD || state_r == ST_SEND || state_r == ST_GAP))
            loaded_r <= (loaded_r + 11'd2 > len_r) ? len_r : loaded_r + 11'd2;
    end

    // No reset on the array; only bytes below the loaded count are ever read
    always_ff @(posedge mclk)
    begin
        if (data_wr && state_r != ST_IDLE && loaded_r < len_r)
            mem[loaded_r[10:1]] <= wdata;
    end

    // Byte index, attempt count and inter-attempt gap
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            idx_r <= 11'd0;
            attempts_r <= 4'h0;
            gap_r <= 8'h00;
        end
        else
        begin
            if (state_r != ST_SEND)
                idx_r <= 11'd0;
            else if (tick)
                idx_r <= idx_r + 11'd1;
            if (state_r == ST_LOAD)
                attempts_r <= 4'h0;
            else if (col_hit)
                attempts_r <= attempts_r + 4'h1;
            gap_r <= (state_r == ST_GAP) ? gap_r + 8'h01 : 8'h00;
        end
    end

    // Outgoing byte stream, one strobe per byte time
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            tx_out_r <= '0;
        else
        begin
            tx_out_r.frame_active <= state_r == ST_SEND && !collision;
            tx_out_r.strobe <= tick && !collision && !starved;
            if (tick)
                tx_out_r.data <= byte_nxt;
        end
    end

    // Configuration registers; new values hold from the next cycle, the line-side levels one cycle after that
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            line_ctl_r <= RST_REG;
            test_ctl_r <= RST_REG;
            tx_cfg_r <= RST_REG;
            buf_cfg_r <= RST_REG;
        end
        else if (wr_strobe)
        begin
            if (addr == OFF_LINE_CTL)
                line_ctl_r <= wdata;
            else if (addr == OFF_TEST_CTL)
                test_ctl_r <= wdata;
            else if (addr == OFF_TX_CFG)
                tx_cfg_r <= wdata;
            else if (addr == OFF_BUF_CFG)
                buf_cfg_r <= wdata;
        end
    end

    // Interface selection and line policy levels toward the line side
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            use_aui_r <= 1'b0;
            mod_backoff_r <= 1'b0;
            defer_off_r <= 1'b0;
        end
        else
        begin
            if (line_ctl_r[LC_FORCE_AUI])
                use_aui_r <= 1'b1;
            else if (line_ctl_r[LC_AUTO_SEL])
                use_aui_r <= !link_ok;
            else
                use_aui_r <= 1'b0;
            mod_backoff_r <= line_ctl_r[LC_MOD_BACKOFF];
            defer_off_r <= line_ctl_r[LC_DEFER_OFF];
        end
    end

    // Sticky flags; a set in the same cycle as the clearing read wins
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            tx_event_r <= RST_REG;
            buf_event_r <= RST_REG;
            bid_error_r <= 1'b0;
        end
        else
        begin
            if (rd_strobe && addr == OFF_TX_EVENT)
                tx_event_r <= RST_REG;
            if (rd_strobe && addr == OFF_BUF_EVENT)
                buf_event_r <= RST_REG;
            if (cmd_wr)
                bid_error_r <= 1'b0;
            if (ok_done)
                tx_event_r[EV_SEND_OK] <= 1'b1;
            if (col_hit)
                tx_event_r[EV_ANY_COL] <= 1'b1;
            if (col_hit && late)
                tx_event_r[EV_LATE_COL] <= 1'b1;
            if (col_hit && attempts_r == MAX_RETRY)
                tx_event_r[EV_SIXTEEN] <= 1'b1;
            if (state_r == ST_SEND && tick && starved)
                buf_event_r[BEV_UNDERRUN] <= 1'b1;
            if (len_wr && state_r == ST_CMD && len_ok && buf_cfg_r[BEV_SPACE])
                buf_event_r[BEV_SPACE] <= 1'b1;
            if (len_wr && state_r == ST_CMD && !len_ok)
                bid_error_r <= 1'b1;
        end
    end

    // Interrupt line is registered and follows the enabled flags one cycle later
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            irq_r <= 1'b0;
        else
            irq_r <= |(tx_event_r & tx_cfg_r) || |(buf_event_r & buf_cfg_r);
    end

    // Read port; unmapped addresses read as zero
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            rdata_r <= 16'h0000;
        else if (rd_strobe)
        begin
            if (addr == OFF_TX_CMD)
                rdata_r <= cmd_word_r;
            else if (addr == OFF_BUS_STATUS)
                rdata_r <= {7'h00, state_r == ST_READY, bid_error_r, 7'h00};
            else if (addr == OFF_LINE_CTL)
                rdata_r <= line_ctl_r;
            else if (addr == OFF_TEST_CTL)
                rdata_r <= test_ctl_r;
            else if (addr == OFF_TX_CFG)
                rdata_r <= tx_cfg_r;
            else if (addr == OFF_BUF_CFG)
                rdata_r <= buf_cfg_r;
            else if (addr == OFF_TX_EVENT)
                rdata_r <= tx_event_r;
            else if (addr == OFF_BUF_EVENT)
                rdata_r <= buf_event_r;
            else
                rdata_r <= 16'h0000;
        end
    end

    // Checks on the block's own behaviour
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    sequence seq_good_bid;
        state_r == ST_CMD && len_wr && len_ok && !cmd_wr;
    endsequence

    sequence seq_commit;
        state_r == ST_READY && status_rd && !cmd_wr;
    endsequence

    a_start_threshold: assert property ($rose(state_r == ST_SEND) |->
        $past(loaded_r) >= $past(thr) && $past(tx_allowed))
        else $error("preamble started below threshold");
    a_abort_flush: assert property (cmd_wr && wdata[CMD_ABORT] |=>
        state_r == ST_IDLE && loaded_r == 11'd0)
        else $error("abort did not flush");
    a_single_try: assert property (col_hit && cmd_r.single_attempt && !cmd_wr |=>
        state_r == ST_IDLE)
        else $error("retry after collision in single-attempt mode");
    a_no_crc_bytes: assert property (state_r == ST_SEND && cmd_r.crc_suppress |->
        !in_crc)
        else $error("crc byte sent while suppressed");
    a_pad_length: assert property (seq_good_bid ##1 !cmd_r.pad_disable |->
        flen_r >= PAD_TO && flen_r >= len_r)
        else $error("short frame not padded");
    a_runt_length: assert property (seq_good_bid ##1 cmd_r.pad_disable |->
        flen_r == len_r)
        else $error("padding added while disabled");
    a_short_refused: assert property (state_r == ST_CMD && len_wr && !cmd_wr &&
        wdata < 16'(LEN_MIN) |=> state_r == ST_IDLE && bid_error_r)
        else $error("short length accepted");
    a_ready_commit: assert property (seq_commit |=> state_r == ST_LOAD ##1
        loaded_r <= 11'd2)
        else $error("ready read did not commit");
    a_send_ok_flag: assert property (ok_done && !cmd_wr |=>
        tx_event_r[EV_SEND_OK] && state_r == ST_IDLE)
        else $error("completion not flagged");
    a_byte_pace: assert property (tx_out_r.strobe && state_r == ST_SEND |=>
        !tx_out_r.strobe [*7])
        else $error("bytes closer than one byte time");

endmodule

// file: verif/host_model.sv
// Host side model: one register access at a time on the parallel port
`timescale 1ns/1ps
module host_model (
    input wire logic mclk, // Device clock
    output logic [11:0] addr, // Byte address
    output logic wr_strobe, // Write pulse
    output logic rd_strobe, // Read pulse
    output logic [15:0] wdata // Write data
);
    initial
    begin
        addr = 12'h000;
        wdata = 16'h0000;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
    end

    // Strobe for one cycle; data is inverted afterwards so stale values never match
    task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(negedge mclk);
        addr <= a;
        wdata <= d;
        wr_strobe <= w;
        rd_strobe <= !w;
        @(negedge mclk);
        wr_strobe <= 1'b0;
        rd_strobe <= 1'b0;
        wdata <= ~d;
    endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the transmit request control block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
module testbench;
    import tx_request_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic link_ok = 1'b1;
    logic collision = 1'b0;
    logic [11:0] addr;
    logic wr_strobe;
    logic rd_strobe;
    logic [15:0] wdata;
    logic [15:0] rdata_r;
    tx_byte_t tx_out;
    logic use_aui_r;
    logic mod_backoff_r;
    logic defer_off_r;
    logic irq_r;
    logic [7:0] exp_q[$];
    logic [7:0] exp_b;
    logic [15:0] cmd;
    logic [15:0] w;
    int failures = 0;
    int comparisons = 0;
    int i;
    int j;
    logic [31:0] crc;
    logic [7:0] b;

    always #50 mclk = ~mclk;

    // Reference CRC step, reflected, one byte lsb first
    function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] v);
        logic [31:0] r;
        r = c;
        for (int k = 0; k < 8; k++)
            r = (r[0] ^ v[k]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction

    host_model hm_u (.mclk(mclk), .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .wdata(wdata));
    tx_request_ctrl dut_u (.mclk(mclk), .reset(reset), .addr(addr), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .wdata(wdata), .rdata_r(rdata_r), .link_ok(link_ok),
        .collision(collision), .tx_out_r(tx_out), .use_aui_r(use_aui_r),
        .mod_backoff_r(mod_backoff_r), .defer_off_r(defer_off_r), .irq_r(irq_r));

    task automatic tally_and_finish;
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Each line byte is matched against the oldest noted byte
    always @(negedge mclk)
        if (tx_out.strobe === 1'b1)
        begin
            exp_b = (exp_q.size() != 0) ? exp_q.pop_front() : ~tx_out.data;
            `CHK("tx byte", exp_b, tx_out.data)
            `CHK("frame active", 1'b1, tx_out.frame_active)
        end

    // Whole run is about two thousand cycles; twice that is a hang
    initial
    begin
        #400000;
        failures++;
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(39));
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        // Forced attachment unit wins over automatic choice
        hm_u.acc(1'b1, OFF_LINE_CTL, 16'h2b00);
        repeat (2) @(negedge mclk);
        `CHK("aui", 1'b1, use_aui_r)
        `CHK("backoff", 1'b1, mod_backoff_r)
        `CHK("deferral", 1'b1, defer_off_r)
        // Automatic choice falls back to the attachment unit without link pulses
        hm_u.acc(1'b1, OFF_LINE_CTL, 16'h0200);
        link_ok = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK("auto aui", 1'b1, use_aui_r)
        link_ok = 1'b1;
        hm_u.acc(1'b1, OFF_LINE_CTL, 16'h0000);
        hm_u.acc(1'b1, OFF_LINE_CTL, 16'h0080);
        hm_u.acc(1'b1, OFF_TX_CFG, 16'h0100);
        repeat (2) @(negedge mclk);
        `CHK("twisted pair", 1'b0, use_aui_r)
        // Two-byte request must be refused
        hm_u.acc(1'b1, OFF_TX_CMD, 16'h3000);
        hm_u.acc(1'b1, OFF_TX_LEN, 16'h0002);
        hm_u.acc(1'b0, OFF_BUS_STATUS, 16'h0000);
        `CHK("bid status", 2'b01, rdata_r[8:7])
        // Six-byte runt, no pad, no CRC, start after five bytes
        cmd = 16'h3000 | (16'($urandom) & 16'h0200);
        hm_u.acc(1'b1, OFF_TX_CMD, cmd);
        hm_u.acc(1'b1, OFF_TX_LEN, 16'h0006);
        hm_u.acc(1'b0, OFF_BUS_STATUS, 16'h0000);
        `CHK("ready", 2'b10, rdata_r[8:7])
        for (i = 0; i < 7; i++)
            exp_q.push_back(PRE_BYTE);
        exp_q.push_back(SFD_BYTE);
        for (i = 0; i < 3; i++)
        begin
            w = 16'($urandom);
            exp_q.push_back(w[7:0]);
            exp_q.push_back(w[15:8]);
            hm_u.acc(1'b1, OFF_TX_DATA, w);
        end
        for (i = 0; i < 400 && exp_q.size() != 0; i++)
            @(negedge mclk);
        repeat (40) @(negedge mclk);
        `CHK("bytes left", 0, exp_q.size())
        `CHK("send ok irq", 1'b1, irq_r)
        hm_u.acc(1'b0, OFF_TX_CMD, 16'h0000);
        `CHK("cmd readback", cmd, rdata_r)
        // Four bytes padded to 60 with CRC on, then the complemented CRC, low byte first
        hm_u.acc(1'b1, OFF_TX_CMD, 16'h0000);
        hm_u.acc(1'b1, OFF_TX_LEN, 16'h0004);
        hm_u.acc(1'b0, OFF_BUS_STATUS, 16'h0000);
        crc = CRC_INIT;
        for (j = 0; j < 68; j++)
        begin
            b = (j < 7) ? PRE_BYTE : (j == 7) ? SFD_BYTE : (j < 12) ? 8'(j) : 8'h00;
            if (j >= 8)
                crc = crc_next(crc, b);
            exp_q.push_back(b);
        end
        for (j = 0; j < 4; j++)
            exp_q.push_back(~crc[8 * j +: 8]);
        hm_u.acc(1'b1, OFF_TX_DATA, 16'h0908);
        hm_u.acc(1'b1, OFF_TX_DATA, 16'h0b0a);
        repeat (700) @(negedge mclk);
        `CHK("padded bytes left", 0, exp_q.size())
        hm_u.acc(1'b0, OFF_TX_EVENT, 16'h0000);
        `CHK("send ok event", 16'h0100, rdata_r)
        // Abort while loading: the half-loaded frame never reaches the line
        hm_u.acc(1'b1, OFF_TX_CMD, 16'h30c0);
        hm_u.acc(1'b1, OFF_TX_LEN, 16'h0004);
        hm_u.acc(1'b0, OFF_BUS_STATUS, 16'h0000);
        hm_u.acc(1'b1, OFF_TX_DATA, 16'($urandom));
        hm_u.acc(1'b1, OFF_TX_CMD, 16'h0100);
        hm_u.acc(1'b1, OFF_TX_DATA, 16'($urandom));
        repeat (200) @(negedge mclk);
        hm_u.acc(1'b0, OFF_BUS_STATUS, 16'h0000);
        `CHK("abort status", 2'b00, rdata_r[8:7])
        // Collision before the first byte: single attempt drops it, else one retry
        for (i = 0; i < 2; i++)
        begin
            cmd = (i == 0) ? 16'h32c0 : 16'h30c0;
            hm_u.acc(1'b1, OFF_TX_CMD, cmd);
            hm_u.acc(1'b1, OFF_TX_LEN, 16'h0004);
            hm_u.acc(1'b0, OFF_BUS_STATUS, 16'h0000);
            for (j = 0; j < 12 && i == 1; j++)
                exp_q.push_back((j < 7) ? PRE_BYTE : (j == 7) ? SFD_BYTE : 8'(j));
            hm_u.acc(1'b1, OFF_TX_DATA, 16'h0908);
            hm_u.acc(1'b1, OFF_TX_DATA, 16'h0b0a);
            collision = 1'b1;
            repeat (3) @(negedge mclk);
            collision = 1'b0;
            repeat (300) @(negedge mclk);
            hm_u.acc(1'b0, OFF_TX_EVENT, 16'h0000);
            `CHK("collision events", (i == 0) ? 16'h0800 : 16'h0900, rdata_r)
            `CHK("retry bytes left", 0, exp_q.size())
        end
        tally_and_finish();
    end
endmodule
